/* hw/apr_pkg.sv */
// shared constants and types for the parallel read port host controller
package apr_pkg;
  // ==========================================================================
  // bus geometry
  localparam int BUS_W = 16;
  localparam int RES_W = 18;
  localparam int CHAN_W = 3;
  localparam int WORD_W = CHAN_W + RES_W;
  localparam int NUM_CHAN = 8;
  localparam int FRAMES = 2 * NUM_CHAN;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 7;
  localparam int RDAT_W = 8;
  localparam int OS_W = 3;
  // ==========================================================================
  // command and read frame field positions on the 16 bus lines, and strap pin values
  localparam int CMD_RW_BIT = 15;
  localparam int CMD_ADDR_LSB = 8;
  localparam int FR2_BIT1_LINE = 15;
  localparam int FR2_BIT0_LINE = 14;
  localparam logic CMD_READ = 1'b1;
  localparam logic CMD_WRITE = 1'b0;
  localparam logic [BUS_W-1:0] EXIT_WORD = 16'h0000;
  localparam logic [OS_W-1:0] OS_SOFTWARE = 3'h7;
  localparam logic [OS_W-1:0] OS_NONE = 3'h0;
  localparam logic PAR_SELECT = 1'b0;
  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int T_STROBE_LOW_NS = 30;
  localparam int T_STROBE_HIGH_NS = 20;
  localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_HIGH_CYC = (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] LOW_LOAD = TMR_W'(STROBE_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] HIGH_LOAD = TMR_W'(STROBE_HIGH_CYC - 1);
  // ==========================================================================
  // states and operations
  typedef enum logic [2:0] {
    APR_IDLE, APR_WAIT_FALL, APR_GUARD, APR_RD_LOW, APR_RD_HIGH,
    APR_PUSH, APR_WR_LOW, APR_WR_HIGH
  } apr_state_type;
  typedef enum logic [1:0] {
    APR_OP_ADC, APR_OP_RREAD, APR_OP_RWRITE, APR_OP_EXIT
  } apr_op_type;
endpackage : apr_pkg

/* hw/apr_stream_if.sv */
// valid/ready stream carrier between the controller and its fifo
`timescale 1ns/100ps
interface apr_stream_if #(
  parameter int W = 21
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : apr_stream_if

/* hw/apr_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module apr_fifo #(
  parameter int W = 21,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // streams
  apr_stream_if.snk in_s,
  apr_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  // ==========================================================================
  // handshakes: full and empty come straight from the count
  assign in_s.ready = (cnt_q != FULL_CNT);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rp_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // pointer and count next values, wrap handles non power of two depth
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == LAST_PTR) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == LAST_PTR) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed since valid gates every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end
endmodule : apr_fifo

/* hw/apr_host.sv */
// host controller that drives the converter's parallel port
`timescale 1ns/100ps
// Function
// - host holds interface select low to use the parallel port
// - chip select may stay low, reads then use read strobe alone
// - read after busy falls or previous results while busy high
// - read begun with busy low may continue into next conversion
// - results update at busy fall; never read at that instant
// - reads started while busy high finish before busy falls
// - register read command: top bit one, address on next seven
// - all lines low for one write cycle leaves register mode
module apr_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // converter pins
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [apr_pkg::BUS_W-1:0] parallel_bus_lines_o,
  output logic parallel_bus_lines_oe_o,
  input wire logic [apr_pkg::BUS_W-1:0] parallel_bus_lines_i,
  input wire logic busy_i,
  input wire logic first_channel_flag_i,
  output logic interface_select_o,
  output logic [apr_pkg::OS_W-1:0] oversample_select_pins_o,
  // static options
  input wire logic software_mode_i,
  input wire logic tie_cs_rd_i,
  // command port
  input wire logic adc_start_i,
  input wire logic reg_req_i,
  input wire logic reg_write_i,
  input wire logic [apr_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [apr_pkg::RDAT_W-1:0] reg_wdata_i,
  input wire logic exit_req_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [apr_pkg::RDAT_W-1:0] reg_rdata_o,
  output logic reg_mode_o,
  output logic sync_err_o,
  input wire logic clear_err_i,
  // result stream, word is {channel, result}
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [apr_pkg::WORD_W-1:0] res_data_o
);
  import apr_pkg::*;

  apr_state_type state_q, state_d;
  apr_op_type op_q, op_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [4:0] frame_q, frame_d;
  logic [RES_W-1:0] res_q, res_d;
  logic cs_n_q, cs_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic [BUS_W-1:0] db_q, db_d;
  logic oe_q, oe_d;
  logic reg_mode_q, reg_mode_d;
  logic [RDAT_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic busy_q;
  logic tmr_zero, err_set;

  apr_stream_if #(.W(WORD_W)) fill_s ();
  apr_stream_if #(.W(WORD_W)) drain_s ();

  // ==========================================================================
  // static straps; the host never uses the serial side
  assign interface_select_o = PAR_SELECT;
  // register access is only offered in software mode
  assign oversample_select_pins_o =
    software_mode_i ? OS_SOFTWARE : OS_NONE;

  // ==========================================================================
  // pin outputs
  // with chip select tied to read, the read strobe doubles as select
  assign cs_n_o = tie_cs_rd_i ? rd_n_q : cs_n_q;
  assign rd_n_o = rd_n_q;
  assign wr_n_o = wr_n_q;
  assign parallel_bus_lines_o = db_q;
  assign parallel_bus_lines_oe_o = oe_q;
  assign done_o = done_q;
  assign reg_rdata_o = rdata_q;
  assign reg_mode_o = reg_mode_q;
  assign sync_err_o = err_q;
  assign cmd_ready_o = (state_q == APR_IDLE);
  assign tmr_zero = (tmr_q == '0);

  // fifo fill side: the push state stalls until there is room
  assign fill_s.valid = (state_q == APR_PUSH);
  assign fill_s.data = {frame_q[3:1], res_q};
  assign res_valid_o = drain_s.valid;
  assign res_data_o = drain_s.data;
  assign drain_s.ready = res_ready_i;

  apr_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) i_apr_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ==========================================================================
  // flag check: high only on channel one's first frame
  always_comb begin
    err_set = 1'b0;
    if (state_q == APR_RD_LOW && op_q == APR_OP_ADC && tmr_zero) begin
      err_set = (frame_q == 5'h00) ? !first_channel_flag_i
                                   : first_channel_flag_i;
    end
    // set wins over clear so a mismatch is never lost
    err_d = err_set ? 1'b1 : (clear_err_i ? 1'b0 : err_q);
  end

  // ==========================================================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    tmr_d = tmr_zero ? tmr_q : tmr_q - 1'b1;
    frame_d = frame_q;
    res_d = res_q;
    cs_n_d = cs_n_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    db_d = db_q;
    oe_d = oe_q;
    reg_mode_d = reg_mode_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    case (state_q)
      APR_IDLE: begin
        cs_n_d = 1'b1;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        oe_d = 1'b0;
        // no conversion data can be read while in register mode
        if (adc_start_i && !reg_mode_q) begin
          op_d = APR_OP_ADC;
          // never start while busy is high: wait for fresh results
          state_d = busy_i ? APR_WAIT_FALL : APR_GUARD;
        end else if (reg_req_i && software_mode_i && !tie_cs_rd_i) begin
          op_d = reg_write_i ? APR_OP_RWRITE : APR_OP_RREAD;
          db_d = {reg_write_i ? CMD_WRITE : CMD_READ, reg_addr_i,
                  reg_write_i ? reg_wdata_i : 8'h00};
          cs_n_d = 1'b0;
          wr_n_d = 1'b0;
          oe_d = 1'b1;
          tmr_d = LOW_LOAD;
          state_d = APR_WR_LOW;
        end else if (exit_req_i && reg_mode_q && !tie_cs_rd_i) begin
          op_d = APR_OP_EXIT;
          db_d = EXIT_WORD;
          cs_n_d = 1'b0;
          wr_n_d = 1'b0;
          oe_d = 1'b1;
          tmr_d = LOW_LOAD;
          state_d = APR_WR_LOW;
        end
      end
      APR_WAIT_FALL: begin
        // the register update happens on this edge, so stay off it
        if (busy_q && !busy_i) begin
          state_d = APR_GUARD;
        end
      end
      APR_GUARD: begin
        // a read begun here may run on past the next conversion start
        cs_n_d = 1'b0;
        rd_n_d = 1'b0;
        frame_d = 5'h00;
        tmr_d = LOW_LOAD;
        state_d = APR_RD_LOW;
      end
      APR_RD_LOW: begin
        if (tmr_zero) begin
          // sample just before the rising strobe, data is settled
          if (op_q == APR_OP_RREAD) begin
            rdata_d = parallel_bus_lines_i[RDAT_W-1:0];
          end else if (!frame_q[0]) begin
            res_d[RES_W-1:2] = parallel_bus_lines_i;
          end else begin
            res_d[1] = parallel_bus_lines_i[FR2_BIT1_LINE];
            res_d[0] = parallel_bus_lines_i[FR2_BIT0_LINE];
          end
          rd_n_d = 1'b1;
          tmr_d = HIGH_LOAD;
          state_d = APR_RD_HIGH;
        end
      end
      APR_RD_HIGH: begin
        if (tmr_zero) begin
          if (op_q == APR_OP_RREAD) begin
            cs_n_d = 1'b1;
            done_d = 1'b1;
            state_d = APR_IDLE;
          end else if (frame_q[0]) begin
            state_d = APR_PUSH;
          end else begin
            // next fall brings the second frame of the same channel
            frame_d = frame_q + 1'b1;
            rd_n_d = 1'b0;
            tmr_d = LOW_LOAD;
            state_d = APR_RD_LOW;
          end
        end
      end
      APR_PUSH: begin
        if (fill_s.ready) begin
          if (frame_q == 5'(FRAMES - 1)) begin
            // select goes high between bursts; when tied it follows the read strobe, which is high too
            cs_n_d = 1'b1;
            done_d = 1'b1;
            state_d = APR_IDLE;
          end else begin
            frame_d = frame_q + 1'b1;
            rd_n_d = 1'b0;
            tmr_d = LOW_LOAD;
            state_d = APR_RD_LOW;
          end
        end
      end
      APR_WR_LOW: begin
        if (tmr_zero) begin
          // the device latches the command on this rising edge
          wr_n_d = 1'b1;
          tmr_d = HIGH_LOAD;
          state_d = APR_WR_HIGH;
        end
      end
      APR_WR_HIGH: begin
        if (tmr_zero) begin
          // bus is released on the same edge that the read frame's strobe falls, so no contention
          oe_d = 1'b0;
          case (op_q)
            APR_OP_RREAD: begin
              reg_mode_d = 1'b1;
              rd_n_d = 1'b0;
              tmr_d = LOW_LOAD;
              state_d = APR_RD_LOW;
            end
            APR_OP_EXIT: begin
              reg_mode_d = 1'b0;
              cs_n_d = 1'b1;
              done_d = 1'b1;
              state_d = APR_IDLE;
            end
            default: begin
              cs_n_d = 1'b1;
              done_d = 1'b1;
              state_d = APR_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_d = APR_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= APR_IDLE;
      op_q <= APR_OP_ADC;
      tmr_q <= '0;
      frame_q <= '0;
      res_q <= '0;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      db_q <= '0;
      oe_q <= 1'b0;
      reg_mode_q <= 1'b0;
      rdata_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      tmr_q <= tmr_d;
      frame_q <= frame_d;
      res_q <= res_d;
      cs_n_q <= cs_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      db_q <= db_d;
      oe_q <= oe_d;
      reg_mode_q <= reg_mode_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      err_q <= err_d;
      busy_q <= busy_i; // edge history for the fall detector
    end
  end
endmodule : apr_host

/* tb/apr_host_checker.sv */
// concurrent checks on the host controller's pins
`timescale 1ns/100ps
module apr_host_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // converter side
  input wire logic cs_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic [apr_pkg::BUS_W-1:0] parallel_bus_lines_o,
  input wire logic parallel_bus_lines_oe_o,
  input wire logic busy_i,
  input wire logic interface_select_o,
  input wire logic [apr_pkg::OS_W-1:0] oversample_select_pins_o,
  // options and status
  input wire logic software_mode_i,
  input wire logic tie_cs_rd_i,
  input wire logic done_o
);
  import apr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  // ==========================================================================
  // strobes idle once reset has been seen
  reset_idle_a: assert property (rst_i |=> cs_n_o && rd_n_o && wr_n_o
    && !parallel_bus_lines_oe_o && !done_o)
    else $error("strobes not idle after reset");
  // ==========================================================================
  // static pins
  select_pin_a: assert property (disable iff (rst_i) !interface_select_o)
    else $error("interface select not low");
  os_pins_a: assert property (disable iff (rst_i)
    oversample_select_pins_o == (software_mode_i ? 3'h7 : 3'h0))
    else $error("oversample pins wrong");
  // ==========================================================================
  // strobe shapes and ordering
  tie_cs_a: assert property (disable iff (rst_i) tie_cs_rd_i |-> cs_n_o == rd_n_o)
    else $error("chip select not following read");
  rd_select_a: assert property (disable iff (rst_i) $fell(rd_n_o) |-> !cs_n_o)
    else $error("read strobe without chip select");
  busy_fall_a: assert property (disable iff (rst_i) $fell(busy_i) |-> !$fell(rd_n_o))
    else $error("read on busy fall");
  rd_pulse_a: assert property (disable iff (rst_i)
    $fell(rd_n_o) |-> !rd_n_o [*3] ##1 rd_n_o)
    else $error("read pulse not three cycles");
  wr_pulse_a: assert property (disable iff (rst_i)
    $fell(wr_n_o) |-> !wr_n_o [*3] ##1 wr_n_o)
    else $error("write pulse not three cycles");
  wr_hold_a: assert property (disable iff (rst_i) $rose(wr_n_o) |->
    $stable(parallel_bus_lines_o) && parallel_bus_lines_oe_o && !cs_n_o)
    else $error("command word not held at write rise");
  // host never fights the device for the bus
  oe_read_a: assert property (disable iff (rst_i)
    parallel_bus_lines_oe_o |-> !cs_n_o && rd_n_o)
    else $error("bus driven outside a write frame");
  done_pulse_a: assert property (disable iff (rst_i) done_o |=> !done_o)
    else $error("done longer than one cycle");
endmodule : apr_host_checker

bind apr_host apr_host_checker i_apr_host_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o),
  .wr_n_o(wr_n_o), .parallel_bus_lines_o(parallel_bus_lines_o),
  .parallel_bus_lines_oe_o(parallel_bus_lines_oe_o), .busy_i(busy_i),
  .interface_select_o(interface_select_o),
  .oversample_select_pins_o(oversample_select_pins_o),
  .software_mode_i(software_mode_i), .tie_cs_rd_i(tie_cs_rd_i),
  .done_o(done_o)
);

/* tb/apr_dev_model.sv */
// behavioural converter with parallel port, strobe-edge driven
`timescale 1ns/100ps
module apr_dev_model (
  // host strobes and bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [apr_pkg::BUS_W-1:0] bus_i,
  input wire logic ifsel_i,
  input wire logic [apr_pkg::OS_W-1:0] os_i,
  // bench controls
  input wire logic conv_i,
  input wire logic [apr_pkg::RES_W-1:0] seed_i,
  input wire logic bad_flag_i,
  // device outputs
  output logic [apr_pkg::BUS_W-1:0] bus_o,
  output logic busy_o,
  output logic flag_o
);
  import apr_pkg::*;
  logic [RES_W-1:0] res_q [NUM_CHAN];
  logic [RDAT_W-1:0] regs_q [128];
  logic [BUS_W-1:0] out_q = 16'h0000;
  logic [ADDR_W-1:0] addr_q = 7'h00;
  logic flag_q = 1'b0;
  logic regm_q = 1'b0;
  int fr_q = 0;
  // register access only with all select pins high and parallel chosen
  wire sw_mode = (os_i == 3'h7) && (ifsel_i == 1'b0);
  initial begin
    busy_o = 1'b0;
    for (int a = 0; a < 128; a++) regs_q[a] = 8'(a) ^ 8'hA5;
    for (int c = 0; c < NUM_CHAN; c++) res_q[c] = 18'h00000;
  end
  // results only change at busy fall, so reads in busy keep old data
  always @(posedge conv_i) begin
    busy_o = 1'b1;
    #400;
    for (int c = 0; c < NUM_CHAN; c++) res_q[c] = seed_i + 18'(c) * 18'h01111;
    fr_q = 0;
    busy_o = 1'b0;
  end
  // read strobe alone steps the frames; chip select is not needed
  always @(negedge rd_n_i) begin
    if (regm_q) out_q = {1'b0, addr_q, regs_q[addr_q]};
    else begin
      out_q = fr_q[0] ? {res_q[fr_q/2][1:0], 14'h0000}
                      : res_q[fr_q/2][17:2];
      flag_q = (fr_q == 0) ^ bad_flag_i;
      fr_q = (fr_q + 1) % FRAMES;
    end
  end
  // command and address latched at write rise
  always @(posedge wr_n_i) begin
    if (sw_mode && cs_n_i === 1'b0) begin
      if (bus_i == 16'h0000) regm_q = 1'b0;
      else if (bus_i[15]) begin
        regm_q = 1'b1;
        addr_q = bus_i[14:8];
      end
      else if (regm_q) regs_q[bus_i[14:8]] = bus_i[7:0];
    end
  end
  // released lines show the inverse of the last value, never a kind level
  assign bus_o = (!cs_n_i && wr_n_i) ? out_q : ~out_q;
  assign flag_o = cs_n_i ? ~flag_q : flag_q;
endmodule : apr_dev_model

/* tb/apr_host_tb.sv */
// self-checking bench for the parallel port host controller
`timescale 1ns/100ps
module apr_host_tb;
  import apr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sw = 1'b1, tie = 1'b0, adc = 1'b0, rreq = 1'b0, rwr = 1'b0;
  logic ext = 1'b0, clr = 1'b0, rdy = 1'b0, conv = 1'b0, bad = 1'b0;
  logic [ADDR_W-1:0] addr = 7'h2A;
  logic [RDAT_W-1:0] wdat = 8'h5C;
  logic [RES_W-1:0] seed = 18'h00000;
  logic cs_n, rd_n, wr_n, oe, busy, flag, ifsel, cmd_rdy, done, regm, serr;
  logic res_valid;
  logic [BUS_W-1:0] bus_o, bus_i, dev_bus;
  logic [OS_W-1:0] os;
  logic [RDAT_W-1:0] rdata;
  logic [WORD_W-1:0] res_data;
  int errors = 0;
  int comparisons = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // the wire carries whoever drives it
  assign bus_i = oe ? bus_o : dev_bus;
  apr_host i_apr_host (.clk_i(clk_i), .rst_i(rst_i), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .parallel_bus_lines_o(bus_o),
    .parallel_bus_lines_oe_o(oe), .parallel_bus_lines_i(bus_i),
    .busy_i(busy), .first_channel_flag_i(flag), .interface_select_o(ifsel),
    .oversample_select_pins_o(os), .software_mode_i(sw), .tie_cs_rd_i(tie),
    .adc_start_i(adc), .reg_req_i(rreq), .reg_write_i(rwr),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .exit_req_i(ext),
    .cmd_ready_o(cmd_rdy), .done_o(done), .reg_rdata_o(rdata),
    .reg_mode_o(regm), .sync_err_o(serr), .clear_err_i(clr),
    .res_valid_o(res_valid), .res_ready_i(rdy), .res_data_o(res_data));
  apr_dev_model i_apr_dev_model (.cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .bus_i(bus_i), .ifsel_i(ifsel), .os_i(os),
    .conv_i(conv), .seed_i(seed), .bad_flag_i(bad), .bus_o(dev_bus),
    .busy_o(busy), .flag_o(flag));
  // ==========================================================================
  // shared tasks
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one-cycle command, then back to quiet
  task automatic issue(logic a, logic r, logic w, logic e);
    @(posedge clk_i);
    #1 {adc, rreq, rwr, ext} = {a, r, w, e};
    @(posedge clk_i);
    #1 {adc, rreq, ext} = 3'h0;
  endtask : issue
  task automatic wait_done(int bound);
    repeat (bound) begin
      @(posedge clk_i);
      #1;
      if (done === 1'b1) return;
    end
    check("done", 1'b0, 1'b1);
    complete_run();
  endtask : wait_done
  // counts done pulses over a stretch where none may come
  task automatic quiet(string name, int n);
    int cnt;
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 if (done === 1'b1) cnt++;
    end
    check(name, cnt, 0);
  endtask : quiet
  task automatic convert(logic [RES_W-1:0] s);
    @(posedge clk_i);
    #1 {seed, conv} = {s, 1'b1};
    @(posedge clk_i);
    #1 conv = 1'b0;
  endtask : convert
  // pops n words with a stall cycle between pops
  task automatic drain(int n, logic [RES_W-1:0] s1, logic [RES_W-1:0] s2);
    logic [RES_W-1:0] r;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 200 && res_valid !== 1'b1; k++) @(posedge clk_i) #1;
      // a word that never arrives is a hang, not a silent pass
      if (res_valid !== 1'b1) begin
        check("valid_wait", res_valid, 1'b1);
        complete_run();
      end
      r = (i < 8 ? s1 : s2) + 18'(i % 8) * 18'h01111;
      check("word", 32'(res_data), {11'h000, 3'(i % 8), r});
      rdy = 1'b1;
      @(posedge clk_i);
      #1 rdy = 1'b0;
      @(posedge clk_i);
      #1;
    end
    check("empty", res_valid, 1'b0);
  endtask : drain
  // ==========================================================================
  // scenarios
  task automatic s_reset();
    check("ready", cmd_rdy, 1'b1);
    check("valid", res_valid, 1'b0);
    check("regmode", regm, 1'b0);
    check("ifsel", ifsel, 1'b0);
    check("os", os, 3'h7);
  endtask : s_reset
  // start in busy, then a second readout stalls on the full buffer
  task automatic s_adc_fill();
    convert(18'h2A5A3);
    issue(1'b1, 1'b0, 1'b0, 1'b0);
    wait_done(300);
    check("syncerr", serr, 1'b0);
    convert(18'h15C0E);
    issue(1'b1, 1'b0, 1'b0, 1'b0);
    quiet("stall", 150);
    drain(16, 18'h2A5A3, 18'h15C0E);
    check("ready2", cmd_rdy, 1'b1);
  endtask : s_adc_fill
  task automatic s_reg();
    issue(1'b0, 1'b1, 1'b0, 1'b0);
    wait_done(40);
    check("regmode1", regm, 1'b1);
    check("rdata", rdata, 8'h2A ^ 8'hA5);
    issue(1'b0, 1'b1, 1'b1, 1'b0);
    wait_done(40);
    issue(1'b0, 1'b1, 1'b0, 1'b0);
    wait_done(40);
    check("rdback", rdata, 8'h5C);
    issue(1'b1, 1'b0, 1'b0, 1'b0);
    quiet("adc_in_reg", 100);
    issue(1'b0, 1'b0, 1'b0, 1'b1);
    wait_done(40);
    check("regmode0", regm, 1'b0);
    check("devmode", i_apr_dev_model.regm_q, 1'b0);
  endtask : s_reg
  task automatic s_refuse();
    @(posedge clk_i);
    #1 sw = 1'b0;
    #1 check("os_hw", os, 3'h0);
    issue(1'b0, 1'b1, 1'b0, 1'b0);
    quiet("refused", 30);
    @(posedge clk_i);
    #1 sw = 1'b1;
  endtask : s_refuse
  // chip select tied to read, then a broken first flag and a re-read
  task automatic s_tie();
    @(posedge clk_i);
    #1 tie = 1'b1;
    // register access is refused while select follows the read strobe
    issue(1'b0, 1'b1, 1'b0, 1'b0);
    quiet("tie_refused", 30);
    convert(18'h3FFFC);
    issue(1'b1, 1'b0, 1'b0, 1'b0);
    wait_done(300);
    drain(8, 18'h3FFFC, 18'h3FFFC);
    bad = 1'b1;
    issue(1'b1, 1'b0, 1'b0, 1'b0);
    wait_done(300);
    check("syncerr1", serr, 1'b1);
    clr = 1'b1;
    @(posedge clk_i);
    #1 clr = 1'b0;
    check("syncerr0", serr, 1'b0);
    drain(8, 18'h3FFFC, 18'h3FFFC);
    {bad, tie} = 2'h0;
  endtask : s_tie
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    s_reset();
    s_adc_fill();
    s_reg();
    s_refuse();
    s_tie();
    complete_run();
  end
endmodule : apr_host_tb
